// ==== logic/asfd_core.sv ====
// set features command decoder with task file and drive settings
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R01: unsupported or invalid subcommand or value ends the command aborted.
// R02: 01h forces byte-wide data, 16-bit indicator off; 81h clears it.
// R03: host must not enable byte-wide mode for dma transfers.
// R04: 02h/82h set write cache; 82h flushes before completion.
// R05: 03h takes transfer type from bits 7:3, mode from bits 2:0.
// R06: type 00001b pio, 00100b mdma, 01000b udma; reserved refused.
// R07: type 00000b mode 001b gives default pio with flow control off.
// R08: exactly one pio and one dma mode selected at all times.
// R09: selecting udma drops mdma and the reverse.
// R10: pio mode 3 or above always runs with flow control.
// R11: 05h enables power management at sector count level; 85h disables.
// R12: level FEh top, 81h-FDh no standby, lower allow standby, FFh reserved; the code also refuses 00h.
// R13: power management level is stored but changes nothing.
// R14: 0Ah/8Ah set power level 1 commands; default disabled.
// R15: 55h read look-ahead off, AAh on; 55h and BBh are defaults.
// R16: BBh selects four extra bytes for long read and write.
// R17: 9Ah takes sector count as quarter of the current budget.
// R18: 9Ah completion returns min in cylinder low, max in cylinder high.
// R19: out of range current limits clamp; power-on default highest.
// R20: 66h/CCh turn default restore on soft reset off/on; default on.
// R21: 69h and 96h complete without error as no-operations.
// R22: applied settings hold until changed, restored or power cycled.
module asfd_core (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire asfd_pkg::asfd_tf_wr_s tf_wr_i,
    input  wire asfd_pkg::asfd_tf_sel_e tf_rsel_i,
    input  wire logic                  data_acc_i,
    input  wire logic                  soft_rst_i,
    input  wire logic                  flush_done_i,
    output logic [7:0]                 tf_rdata_o,
    output logic                       busy_o,
    output logic                       done_o,
    output logic                       abort_o,
    output logic                       flush_req_o,
    output logic                       wide16_n_o,
    output logic                       iordy_en_o,
    output asfd_pkg::asfd_cfg_s        cfg_o
);

    // ------------------------------------------------------------
    // state and task file registers
    // ------------------------------------------------------------
    asfd_pkg::asfd_state_e state_r, state_nxt;
    asfd_pkg::asfd_cfg_s   cfg_r, cfg_nxt;
    logic [7:0]            feat_r, scnt_r, snum_r, cyll_r, cylh_r, drv_r;
    logic [7:0]            cyll_nxt, cylh_nxt;
    logic                  abort_r, abort_nxt;
    logic [7:0]            rdata_r, rdata_nxt;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // host writes only land while idle, so fields stay put during a command
    wire logic idle      = (state_r == asfd_pkg::ST_IDLE);
    wire logic exec      = (state_r == asfd_pkg::ST_EXEC);
    wire logic host_wr   = tf_wr_i.we && idle;
    wire logic cmd_start = host_wr && (tf_wr_i.sel == asfd_pkg::TF_CMD)
                           && (tf_wr_i.data == asfd_pkg::CMD_SET_FEAT);
    wire logic wr_feat   = host_wr && (tf_wr_i.sel == asfd_pkg::TF_FEAT);
    wire logic wr_scnt   = host_wr && (tf_wr_i.sel == asfd_pkg::TF_SCNT);
    wire logic wr_snum   = host_wr && (tf_wr_i.sel == asfd_pkg::TF_SNUM);
    wire logic wr_cyll   = host_wr && (tf_wr_i.sel == asfd_pkg::TF_CYLL);
    wire logic wr_cylh   = host_wr && (tf_wr_i.sel == asfd_pkg::TF_CYLH);
    wire logic wr_drv    = host_wr && (tf_wr_i.sel == asfd_pkg::TF_DRV);
    // soft reset restores defaults only while the restore option is on
    wire logic srst_load = soft_rst_i && cfg_r.por_srst;

    // R12 reserved levels refused
    wire logic apm_ok = (scnt_r != asfd_pkg::APM_RSVD_LO)
                        && (scnt_r != asfd_pkg::APM_RSVD_HI);

    // ------------------------------------------------------------
    // helpers: transfer mode check and current clamp
    // ------------------------------------------------------------
    logic       xm_ok, xm_iordy;
    logic [2:0] xm_pio, xm_dmode;
    logic [1:0] xm_kind;
    logic [7:0] cur_lim;

    // R05 field split
    asfd_xfer_mode u_xfer (
        .cfg_i   (scnt_r),
        .pio_i   (cfg_r.pio),
        .iordy_i (cfg_r.iordy),
        .kind_i  (cfg_r.dma_kind),
        .dmode_i (cfg_r.dma_mode),
        .ok_o    (xm_ok),
        .pio_o   (xm_pio),
        .iordy_o (xm_iordy),
        .kind_o  (xm_kind),
        .dmode_o (xm_dmode)
    );

    // R19 clamp to range
    asfd_cur_clamp u_cur (
        .req_i (scnt_r),
        .lim_o (cur_lim)
    );

    // ------------------------------------------------------------
    // subcommand execution
    // ------------------------------------------------------------
    // one pass per command; the case default refuses any unknown code
    logic feat_ok;
    always_comb begin
        cfg_nxt  = cfg_r;
        feat_ok  = 1'b1;
        cyll_nxt = cyll_r;
        cylh_nxt = cylh_r;
        case (feat_r)
            // R02 byte-wide mode
            asfd_pkg::SF_BYTE_ON:  cfg_nxt.byte_mode = 1'b1;
            asfd_pkg::SF_BYTE_OFF: cfg_nxt.byte_mode = 1'b0;
            // R04 cache on; off is applied after the flush
            asfd_pkg::SF_WC_ON:    cfg_nxt.wcache = 1'b1;
            asfd_pkg::SF_WC_OFF:   cfg_nxt.wcache = cfg_r.wcache;
            // R06 R07 R08 R09 mode taken only when valid
            asfd_pkg::SF_XFER: begin
                feat_ok           = xm_ok;
                cfg_nxt.pio       = xm_pio;
                cfg_nxt.iordy     = xm_iordy;
                cfg_nxt.dma_kind  = xm_kind;
                cfg_nxt.dma_mode  = xm_dmode;
            end
            // R11 R13 level stored, no other effect
            asfd_pkg::SF_APM_ON: begin
                feat_ok         = apm_ok;
                cfg_nxt.apm_en  = apm_ok ? 1'b1 : cfg_r.apm_en;
                cfg_nxt.apm_lvl = apm_ok ? scnt_r : cfg_r.apm_lvl;
            end
            asfd_pkg::SF_APM_OFF:  cfg_nxt.apm_en = 1'b0;
            asfd_pkg::SF_EXTP_ON:  cfg_nxt.ext_pwr = 1'b1;
            asfd_pkg::SF_EXTP_OFF: cfg_nxt.ext_pwr = 1'b0;
            // R14 power level 1
            asfd_pkg::SF_PL1_ON:   cfg_nxt.pl1 = 1'b1;
            asfd_pkg::SF_PL1_OFF:  cfg_nxt.pl1 = 1'b0;
            // R15 look-ahead
            asfd_pkg::SF_RLA_OFF:  cfg_nxt.lookahead = 1'b0;
            asfd_pkg::SF_RLA_ON:   cfg_nxt.lookahead = 1'b1;
            // R20 restore on soft reset
            asfd_pkg::SF_POR_OFF:  cfg_nxt.por_srst = 1'b0;
            asfd_pkg::SF_POR_ON:   cfg_nxt.por_srst = 1'b1;
            // R21 accepted, nothing changes
            asfd_pkg::SF_NOP_A:    feat_ok = 1'b1;
            asfd_pkg::SF_NOP_B:    feat_ok = 1'b1;
            asfd_pkg::SF_COMPAT:   feat_ok = 1'b1;
            // R17 R18 budget set, range reported
            asfd_pkg::SF_CUR_LIM: begin
                cfg_nxt.cur_lim = cur_lim;
                cyll_nxt        = asfd_pkg::CUR_MIN;
                cylh_nxt        = asfd_pkg::CUR_MAX;
            end
            // R16 four extra bytes on long commands
            asfd_pkg::SF_LONG4:    cfg_nxt.long4 = 1'b1;
            // R01 unknown code
            default:               feat_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wire logic do_flush = exec && feat_ok && (feat_r == asfd_pkg::SF_WC_OFF);
    wire logic flushing = (state_r == asfd_pkg::ST_FLUSH);

    always_comb begin
        case (state_r)
            asfd_pkg::ST_IDLE:  state_nxt = cmd_start ? asfd_pkg::ST_EXEC : asfd_pkg::ST_IDLE;
            asfd_pkg::ST_EXEC:  state_nxt = do_flush ? asfd_pkg::ST_FLUSH : asfd_pkg::ST_DONE;
            asfd_pkg::ST_FLUSH: state_nxt = flush_done_i ? asfd_pkg::ST_DONE : asfd_pkg::ST_FLUSH;
            asfd_pkg::ST_DONE:  state_nxt = asfd_pkg::ST_IDLE;
            default:            state_nxt = asfd_pkg::ST_IDLE;
        endcase
    end

    // R01 abort flag held until the next command starts
    assign abort_nxt = exec ? !feat_ok : (cmd_start ? 1'b0 : abort_r);

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    wire logic [7:0] status_b = (8'(busy_o) << asfd_pkg::ST_BSY_BIT)
                              | (8'(!busy_o) << asfd_pkg::ST_DRDY_BIT)
                              | (8'(abort_r) << asfd_pkg::ST_ERR_BIT);
    wire logic [7:0] error_b  = 8'(abort_r) << asfd_pkg::ER_ABRT_BIT;

    always_comb begin
        case (tf_rsel_i)
            asfd_pkg::TF_FEAT: rdata_nxt = error_b;
            asfd_pkg::TF_SCNT: rdata_nxt = scnt_r;
            asfd_pkg::TF_SNUM: rdata_nxt = snum_r;
            asfd_pkg::TF_CYLL: rdata_nxt = cyll_r;
            asfd_pkg::TF_CYLH: rdata_nxt = cylh_r;
            asfd_pkg::TF_DRV:  rdata_nxt = drv_r;
            asfd_pkg::TF_CMD:  rdata_nxt = status_b;
            default:           rdata_nxt = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    // task file bytes written by the host
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            feat_r <= 8'h00;
            scnt_r <= 8'h00;
            snum_r <= 8'h00;
            drv_r  <= 8'h00;
        end else begin
            feat_r <= wr_feat ? tf_wr_i.data : feat_r;
            scnt_r <= wr_scnt ? tf_wr_i.data : scnt_r;
            snum_r <= wr_snum ? tf_wr_i.data : snum_r;
            drv_r  <= wr_drv  ? tf_wr_i.data : drv_r;
        end
    end

    // cylinder bytes: host writes, or range report at execution
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cyll_r <= 8'h00;
            cylh_r <= 8'h00;
        end else begin
            cyll_r <= exec ? cyll_nxt : (wr_cyll ? tf_wr_i.data : cyll_r);
            cylh_r <= exec ? cylh_nxt : (wr_cylh ? tf_wr_i.data : cylh_r);
        end
    end

    // R22 settings move only on execution, flush end or soft reset
    // R20 soft reset loses to a command in flight on purpose: none can run
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r <= asfd_pkg::CFG_DEFAULT;
        end else if (exec && feat_ok) begin
            cfg_r <= cfg_nxt;
        end else if (flushing && flush_done_i) begin
            cfg_r.wcache <= 1'b0;
        end else if (srst_load && idle) begin
            cfg_r <= asfd_pkg::CFG_DEFAULT;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= asfd_pkg::ST_IDLE;
            abort_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            abort_r <= abort_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tf_rdata_o  = rdata_r;
    assign busy_o      = !idle;
    assign done_o      = (state_r == asfd_pkg::ST_DONE);
    assign abort_o     = abort_r;
    // R04 flush requested until the store confirms
    assign flush_req_o = flushing;
    // R02 indicator never asserted in byte-wide mode
    assign wide16_n_o  = !(data_acc_i && !cfg_r.byte_mode);
    // R10 flow control forced at the faster pio modes
    assign iordy_en_o  = cfg_r.iordy || (cfg_r.pio >= asfd_pkg::PIO_IORDY_MIN);
    assign cfg_o       = cfg_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    AST_ABORT_UNKNOWN: assert property ( // R01
        exec && !feat_ok |=> abort_o && done_o && $stable(cfg_o))
        else $error("bad subcommand not aborted");

    AST_BYTE_MODE: assert property ( // R02
        cfg_o.byte_mode |-> wide16_n_o)
        else $error("16-bit indicator asserted in byte mode");

    AST_FLUSH_FIRST: assert property ( // R04
        exec && feat_r == asfd_pkg::SF_WC_OFF |=> flush_req_o && !done_o)
        else $error("cache-off completed without flush");

    // R04 no completion while the store flushes
    AST_FLUSH_HOLD: assert property ( // R04
        flush_req_o && !flush_done_i |=> flush_req_o && !done_o)
        else $error("completion reported during flush");

    AST_FLUSH_END: assert property ( // R04
        flush_req_o && flush_done_i |=> done_o && !cfg_o.wcache ##1 !busy_o)
        else $error("flush end not completed");

    AST_UDMA_DROP: assert property ( // R09
        exec && feat_r == asfd_pkg::SF_XFER && scnt_r[7:3] == asfd_pkg::XT_UDMA
        && xm_ok |=> cfg_o.dma_kind == asfd_pkg::DK_UDMA && !abort_o)
        else $error("udma select failed");

    AST_IORDY_FAST: assert property ( // R10
        cfg_o.pio >= asfd_pkg::PIO_IORDY_MIN |-> iordy_en_o)
        else $error("flow control off at fast pio");

    AST_IORDY_OFF: assert property ( // R07
        exec && feat_r == asfd_pkg::SF_XFER && scnt_r == 8'h01
        |=> cfg_o.pio == asfd_pkg::PIO_DEF && !iordy_en_o)
        else $error("default pio with flow control off not set");

    AST_APM_LEVEL: assert property ( // R11
        exec && feat_r == asfd_pkg::SF_APM_ON && apm_ok
        |=> cfg_o.apm_en && cfg_o.apm_lvl == $past(scnt_r))
        else $error("power level not stored");

    AST_CUR_RANGE: assert property ( // R18
        exec && feat_r == asfd_pkg::SF_CUR_LIM |=> cyll_r == asfd_pkg::CUR_MIN
        && cylh_r == asfd_pkg::CUR_MAX && cfg_o.cur_lim >= asfd_pkg::CUR_MIN
        && cfg_o.cur_lim <= asfd_pkg::CUR_MAX)
        else $error("current range not reported");

    AST_NOP_OK: assert property ( // R21
        exec && (feat_r == asfd_pkg::SF_NOP_A || feat_r == asfd_pkg::SF_NOP_B)
        |=> done_o && !abort_o && $stable(cfg_o))
        else $error("nop subcommand not accepted");

    AST_SRST_RESTORE: assert property ( // R20
        idle && soft_rst_i && cfg_o.por_srst |=> cfg_o == asfd_pkg::CFG_DEFAULT)
        else $error("defaults not restored on soft reset");

    AST_HOLD: assert property ( // R22
        idle && !soft_rst_i |=> $stable(cfg_o))
        else $error("settings changed while idle");

    AST_DONE_TIME: assert property ( // R01
        cmd_start |=> exec ##1 (done_o || flush_req_o))
        else $error("command not finished in two cycles");

endmodule

`default_nettype wire

// ==== logic/asfd_pkg.sv ====
// shared constants and types for the set features decoder
package asfd_pkg;

    // ------------------------------------------------------------
    // command and subcommand codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SET_FEAT  = 8'hEF;
    localparam logic [7:0] SF_BYTE_ON    = 8'h01;
    localparam logic [7:0] SF_BYTE_OFF   = 8'h81;
    localparam logic [7:0] SF_WC_ON      = 8'h02;
    localparam logic [7:0] SF_WC_OFF     = 8'h82;
    localparam logic [7:0] SF_XFER       = 8'h03;
    localparam logic [7:0] SF_APM_ON     = 8'h05;
    localparam logic [7:0] SF_APM_OFF    = 8'h85;
    localparam logic [7:0] SF_EXTP_ON    = 8'h09;
    localparam logic [7:0] SF_EXTP_OFF   = 8'h89;
    localparam logic [7:0] SF_PL1_ON     = 8'h0A;
    localparam logic [7:0] SF_PL1_OFF    = 8'h8A;
    localparam logic [7:0] SF_RLA_OFF    = 8'h55;
    localparam logic [7:0] SF_RLA_ON     = 8'hAA;
    localparam logic [7:0] SF_POR_OFF    = 8'h66;
    localparam logic [7:0] SF_POR_ON     = 8'hCC;
    localparam logic [7:0] SF_NOP_A      = 8'h69;
    localparam logic [7:0] SF_NOP_B      = 8'h96;
    localparam logic [7:0] SF_COMPAT     = 8'h97;
    localparam logic [7:0] SF_CUR_LIM    = 8'h9A;
    localparam logic [7:0] SF_LONG4      = 8'hBB;

    // ------------------------------------------------------------
    // transfer mode field encodings and supported limits
    // ------------------------------------------------------------
    localparam logic [4:0] XT_PIO_DEF    = 5'h00;
    localparam logic [4:0] XT_PIO_FC     = 5'h01;
    localparam logic [4:0] XT_MDMA       = 5'h04;
    localparam logic [4:0] XT_UDMA       = 5'h08;
    localparam logic [2:0] XM_DEF        = 3'h0;
    localparam logic [2:0] XM_IORDY_OFF  = 3'h1;
    localparam logic [2:0] PIO_DEF       = 3'h0;
    localparam logic [2:0] PIO_MAX       = 3'h4;
    localparam logic [2:0] PIO_IORDY_MIN = 3'h3;
    localparam logic [2:0] MDMA_MAX      = 3'h2;
    localparam logic [2:0] UDMA_MAX      = 3'h2;
    localparam logic       IORDY_DIS_OK  = 1'b1;
    localparam logic [1:0] DK_MDMA       = 2'h1;
    localparam logic [1:0] DK_UDMA       = 2'h2;

    // ------------------------------------------------------------
    // power and current limit values
    // ------------------------------------------------------------
    localparam logic [7:0] APM_RSVD_LO   = 8'h00;
    localparam logic [7:0] APM_RSVD_HI   = 8'hFF;
    localparam logic [7:0] APM_MAX_PERF  = 8'hFE;
    localparam logic [7:0] CUR_MIN       = 8'h02;
    localparam logic [7:0] CUR_MAX       = 8'h7D;

    // ------------------------------------------------------------
    // task file selects and status bit positions
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TF_DATA = 3'h0, TF_FEAT = 3'h1, TF_SCNT = 3'h2, TF_SNUM = 3'h3,
        TF_CYLL = 3'h4, TF_CYLH = 3'h5, TF_DRV  = 3'h6, TF_CMD  = 3'h7
    } asfd_tf_sel_e;
    localparam int ST_BSY_BIT  = 7;
    localparam int ST_DRDY_BIT = 6;
    localparam int ST_ERR_BIT  = 0;
    localparam int ER_ABRT_BIT = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_FLUSH = 2'b11, ST_DONE = 2'b10
    } asfd_state_e;

    typedef struct packed {
        logic         we;
        asfd_tf_sel_e sel;
        logic [7:0]   data;
    } asfd_tf_wr_s;

    typedef struct packed {
        logic       byte_mode;
        logic       wcache;
        logic       iordy;
        logic [2:0] pio;
        logic [1:0] dma_kind;
        logic [2:0] dma_mode;
        logic       apm_en;
        logic [7:0] apm_lvl;
        logic       ext_pwr;
        logic       pl1;
        logic       lookahead;
        logic       long4;
        logic [7:0] cur_lim;
        logic       por_srst;
    } asfd_cfg_s;

    localparam asfd_cfg_s CFG_DEFAULT = '{
        byte_mode: 1'b0, wcache: 1'b0, iordy: 1'b1, pio: PIO_DEF,
        dma_kind: DK_MDMA, dma_mode: 3'h0, apm_en: 1'b0,
        apm_lvl: APM_MAX_PERF, ext_pwr: 1'b0, pl1: 1'b0,
        lookahead: 1'b0, long4: 1'b1, cur_lim: CUR_MAX, por_srst: 1'b1
    };

endpackage

// ==== logic/asfd_xfer_mode.sv ====
// transfer mode field checker and mode selector
`timescale 1ns/1ps
`default_nettype none

module asfd_xfer_mode (
    input  wire logic [7:0] cfg_i,
    input  wire logic [2:0] pio_i,
    input  wire logic       iordy_i,
    input  wire logic [1:0] kind_i,
    input  wire logic [2:0] dmode_i,
    output logic            ok_o,
    output logic [2:0]      pio_o,
    output logic            iordy_o,
    output logic [1:0]      kind_o,
    output logic [2:0]      dmode_o
);
    wire logic [4:0] xtype = cfg_i[7:3];
    wire logic [2:0] xmode = cfg_i[2:0];

    // unlisted or reserved types fall to default and are refused
    always_comb begin
        ok_o    = 1'b0;
        pio_o   = pio_i;
        iordy_o = iordy_i;
        kind_o  = kind_i;
        dmode_o = dmode_i;
        case (xtype)
            asfd_pkg::XT_PIO_DEF: begin
                if (xmode == asfd_pkg::XM_DEF) begin
                    ok_o    = 1'b1;
                    pio_o   = asfd_pkg::PIO_DEF;
                    iordy_o = 1'b1;
                end else if (xmode == asfd_pkg::XM_IORDY_OFF && asfd_pkg::IORDY_DIS_OK) begin
                    ok_o    = 1'b1;
                    pio_o   = asfd_pkg::PIO_DEF;
                    iordy_o = 1'b0;
                end
            end
            asfd_pkg::XT_PIO_FC: begin
                ok_o    = (xmode <= asfd_pkg::PIO_MAX);
                pio_o   = ok_o ? xmode : pio_i;
                iordy_o = ok_o ? 1'b1 : iordy_i;
            end
            // one dma kind field, so picking one drops the other
            asfd_pkg::XT_MDMA: begin
                ok_o    = (xmode <= asfd_pkg::MDMA_MAX);
                kind_o  = ok_o ? asfd_pkg::DK_MDMA : kind_i;
                dmode_o = ok_o ? xmode : dmode_i;
            end
            asfd_pkg::XT_UDMA: begin
                ok_o    = (xmode <= asfd_pkg::UDMA_MAX);
                kind_o  = ok_o ? asfd_pkg::DK_UDMA : kind_i;
                dmode_o = ok_o ? xmode : dmode_i;
            end
            default: ok_o = 1'b0;
        endcase
    end
endmodule

`default_nettype wire

// ==== logic/asfd_cur_clamp.sv ====
// current limit clamp to the supported range
`timescale 1ns/1ps
`default_nettype none

module asfd_cur_clamp (
    input  wire logic [7:0] req_i,
    output logic [7:0]      lim_o
);
    wire logic below = (req_i < asfd_pkg::CUR_MIN);
    wire logic above = (req_i > asfd_pkg::CUR_MAX);

    // out of range values are taken, not refused: nearest end wins
    assign lim_o = below ? asfd_pkg::CUR_MIN :
                   above ? asfd_pkg::CUR_MAX : req_i;
endmodule

`default_nettype wire

// ==== tb/asfd_host.sv ====
// host model: task file byte writes and registered reads
`timescale 1ns/1ps
`default_nettype none
module asfd_host (
    input  wire logic              mclk_i,
    input  wire logic [7:0]        rdata_i,
    output asfd_pkg::asfd_tf_wr_s  tf_wr_o,
    output asfd_pkg::asfd_tf_sel_e tf_rsel_o
);
    initial begin
        tf_wr_o = '0;
        tf_rsel_o = asfd_pkg::TF_DATA;
    end
    // value bytes go before the code; no dma is ever moved here
    task automatic wr(input asfd_pkg::asfd_tf_sel_e s, input logic [7:0] d);
        @(posedge mclk_i);
        #1 tf_wr_o = '{1'b1, s, d};
        @(posedge mclk_i);
        #1 tf_wr_o.we = 1'b0;
    endtask
    // read data lands on the same edge that samples the select
    task automatic rd(input asfd_pkg::asfd_tf_sel_e s, output logic [7:0] d);
        @(posedge mclk_i);
        #1 tf_rsel_o = s;
        @(posedge mclk_i);
        #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== tb/ata_set_features_decoder_test.sv ====
// self-checking bench for the set features decoder
`timescale 1ns/1ps
`default_nettype none
module ata_set_features_decoder_test;
    logic mclk_i, rst_i, da, srst, fd, busy, done, ab_o, freq, w16n, ioen;
    logic [7:0] rdata;
    asfd_pkg::asfd_tf_wr_s wr;
    asfd_pkg::asfd_tf_sel_e rs;
    asfd_pkg::asfd_cfg_s cfg;
    int num_errors, checks_done, cyc, wc, bm, pio, dk, cl;
    asfd_host host (.mclk_i(mclk_i), .rdata_i(rdata), .tf_wr_o(wr), .tf_rsel_o(rs));
    asfd_core DUT (.mclk_i(mclk_i), .rst_i(rst_i), .tf_wr_i(wr), .tf_rsel_i(rs),
        .data_acc_i(da), .soft_rst_i(srst), .flush_done_i(fd), .tf_rdata_o(rdata),
        .busy_o(busy), .done_o(done), .abort_o(ab_o), .flush_req_o(freq),
        .wide16_n_o(w16n), .iordy_en_o(ioen), .cfg_o(cfg));
    initial begin
        mclk_i = 0;
        forever #50 mclk_i = ~mclk_i;
    end
    // flush store answers one cycle after each request
    always @(posedge mclk_i) fd <= freq;
    always @(posedge mclk_i) if (++cyc == 20000) begin
        num_errors++;
        finish_test();
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one command through the task file, then compare with the model
    task automatic cmd(input logic [7:0] f, input logic [7:0] s);
        logic [7:0] r;
        int n, t, m;
        logic ab;
        t = s[7:3];
        m = s[2:0];
        ab = !(f inside {8'h01, 8'h81, 8'h02, 8'h82, 8'h03, 8'h05, 8'h85, 8'h09, 8'h89,
            8'h0A, 8'h8A, 8'h55, 8'hAA, 8'h66, 8'hCC, 8'h69, 8'h96, 8'h97, 8'h9A, 8'hBB})
            || (f == 8'h03 && !((t == 0 && m < 2) || (t == 1 && m < 5)
            || ((t == 4 || t == 8) && m < 3))) || (f == 8'h05 && (s == 0 || s == 8'hFF));
        @(posedge mclk_i);
        #1 da = 1'($urandom);
        host.wr(asfd_pkg::TF_FEAT, f);
        host.wr(asfd_pkg::TF_SCNT, s);
        host.wr(asfd_pkg::TF_CMD, 8'hEF);
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(negedge mclk_i);
            n++;
        end
        if (!ab) begin
            if (f == 8'h01 || f == 8'h81) bm = (f == 8'h01);
            if (f == 8'h02 || f == 8'h82) wc = (f == 8'h02);
            if (f == 8'h9A) cl = s < 2 ? 2 : (s > 8'h7D ? 8'h7D : s);
            if (f == 8'h03 && t < 2) pio = t ? m : 0;
            if (f == 8'h03 && t > 3) dk = t >> 2;
        end
        chk({done, busy, ab_o}, {1'b1, 1'b1, ab});
        chk({cfg.byte_mode, cfg.wcache, cfg.pio, cfg.dma_kind, cfg.cur_lim},
            {bm[0], wc[0], pio[2:0], dk[1:0], cl[7:0]});
        chk(w16n, !(da & !bm[0]));
        if (pio > 2) chk(ioen, 1'b1);
        if (f == 8'h03 && !ab && t == 0) chk(ioen, m == 0);
        host.rd(asfd_pkg::TF_FEAT, r);
        chk(r, {5'h00, ab, 2'b00});
        host.rd(asfd_pkg::TF_CMD, r);
        chk(r, {2'b01, 5'h00, ab});
        if (f == 8'h9A) begin
            host.rd(asfd_pkg::TF_CYLL, r);
            chk(r, 8'h02);
            host.rd(asfd_pkg::TF_CYLH, r);
            chk(r, 8'h7D);
        end
    endtask
    initial begin
        logic [7:0] f;
        logic [55:0] pick;
        rst_i = 1;
        da = 0;
        srst = 0;
        pick = {8'h01, 8'h81, 8'h02, 8'h82, 8'h05, 8'h9A, 8'h69};
        {wc, bm, pio, dk, cl} = {32'h0, 32'h0, 32'h0, 32'h1, 32'h7D};
        void'($urandom(32'h9FEF));
        repeat (16) @(posedge mclk_i);
        #1 rst_i = 0;
        chk(cfg, asfd_pkg::CFG_DEFAULT);
        for (int i = 0; i < 300; i++) begin
            f = (i % 7 == 0) ? 8'h03 : ((i % 11 == 0) ? 8'($urandom) : 8'h00);
            if (f == 8'h00) f = pick[($urandom % 7) * 8 +: 8];
            // type mask keeps 0, 1, 4, 8 and the reserved 10000b
            cmd(f, f == 8'h03 ? {5'(32'h1 << ($urandom % 5)) & 5'h1D, 3'($urandom)}
                : 8'($urandom));
        end
        // soft reset keeps settings with restore off, restores with it on
        for (int k = 0; k < 2; k++) begin
            cmd(k ? 8'hCC : 8'h66, 8'h00);
            @(posedge mclk_i);
            #1 srst = 1;
            @(posedge mclk_i);
            #1 srst = 0;
            @(negedge mclk_i);
            if (k) chk(cfg, asfd_pkg::CFG_DEFAULT);
            else chk(cfg.por_srst, 1'b0);
        end
        finish_test();
    end
endmodule
`default_nettype wire
